// ===== core/nhb_pkg.sv
// Purpose: Shared constants and types for the node heartbeat, identity and fault policy entries.
// Assumes: One 125 MHz clock; entries sit at a 16-bit index and an 8-bit sub-index.
// Notes: Every offset, count, reset value and code that more than one file needs lives here.
package nhb_pkg;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 8;
   localparam int HB_UNIT_MS = 1;
   localparam int NS_PER_MS = 1000000;
   localparam int TICK_CYCLES = (HB_UNIT_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TICK_W = 17;
   // ---------------------------------------------------------------
   // Dictionary indices and sub-indices
   // ---------------------------------------------------------------
   localparam logic [15:0] IDX_HB_PERIOD = 16'h1017;
   localparam logic [15:0] IDX_IDENTITY = 16'h1018;
   localparam logic [15:0] IDX_BUILD = 16'h1020;
   localparam logic [15:0] IDX_FAULT = 16'h1029;
   localparam logic [7:0] SUB_COUNT = 8'h00;
   localparam logic [7:0] SUB_VENDOR = 8'h01;
   localparam logic [7:0] SUB_PRODUCT = 8'h02;
   localparam logic [7:0] SUB_REVISION = 8'h03;
   localparam logic [7:0] SUB_SERIAL = 8'h04;
   localparam logic [7:0] SUB_DATE = 8'h01;
   localparam logic [7:0] SUB_TIME = 8'h02;
   localparam logic [7:0] SUB_FAULT_FIRST = 8'h01;
   localparam logic [7:0] SUB_FAULT_LAST = 8'h05;
   // ---------------------------------------------------------------
   // Counts, limits and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] IDENTITY_COUNT = 8'h04;
   localparam logic [7:0] BUILD_COUNT = 8'h02;
   localparam logic [7:0] FAULT_COUNT = 8'h05;
   localparam int FAULT_CLASSES = 5;
   localparam int RPDO_COUNT = 4;
   localparam logic [15:0] HB_PERIOD_RESET = 16'h0000;
   localparam logic [15:0] HB_PERIOD_MIN = 16'h000a;
   localparam logic [15:0] HB_CNT_LAST = 16'h0001;
   localparam logic [15:0] TIME_UPPER = 16'h0000;
   localparam logic [7:0] REV_OD_MAJOR_RST = 8'h00;
   localparam logic [7:0] REV_SW_MAJOR_RST = 8'h01;
   localparam logic [7:0] REV_SW_MINOR_RST = 8'h00;
   localparam logic [7:0] REV_HW_MINOR_RST = 8'h00;
   // ---------------------------------------------------------------
   // Fault reaction codes
   // ---------------------------------------------------------------
   localparam logic [7:0] REACT_PREOP = 8'h00;
   localparam logic [7:0] REACT_KEEP = 8'h01;
   localparam logic [7:0] REACT_STOP = 8'h02;
   localparam logic [7:0] REACT_RESET = REACT_KEEP;
   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      NHB_ABT_NONE = 2'h0,
      NHB_ABT_NO_OBJ = 2'h1,
      NHB_ABT_READ_ONLY = 2'h2,
      NHB_ABT_RANGE = 2'h3
   } nhb_abort_type;
   typedef enum logic {
      NHB_GO_PREOP = 1'h0,
      NHB_GO_STOPPED = 1'h1
   } nhb_go_type;
   typedef enum logic {
      NHB_HB_OFF = 1'h0,
      NHB_HB_RUN = 1'h1
   } nhb_hb_state_type;
endpackage

// ===== core/nhb_hb_if.sv
// Purpose: Carries the millisecond tick, period and expiry between the dictionary and the heartbeat timer.
// Assumes: All signals live in the one clock domain.
// Notes: The dictionary drives period and load; the tick and beat come back from the timers.
`timescale 1ns/1ps
`default_nettype none
interface nhb_hb_if;
   logic tick;
   logic load;
   logic [15:0] period;
   logic beat;
   modport tk (input load, output tick);
   modport bt (input tick, input load, input period, output beat);
   modport ctl (input beat, output load, output period);
endinterface
`default_nettype wire

// ===== core/nhb_tick.sv
// Purpose: Divides the system clock down to a one-cycle pulse every heartbeat time unit.
// Assumes: TICK_CYCLES is at least two.
// Notes: The phase restarts on load so the first interval after a write is a full unit.
`timescale 1ns/1ps
`default_nettype none
module nhb_tick #(
   parameter int TICK_CYCLES = nhb_pkg::TICK_CYCLES
) (
   input wire logic clock,
   input wire logic arst_n,
   nhb_hb_if.tk hb
);
   typedef struct packed {
      logic [nhb_pkg::TICK_W-1:0] cnt;
      logic tick;
   } nhb_tick_state_type;

   localparam logic [nhb_pkg::TICK_W-1:0] CNT_END = nhb_pkg::TICK_W'(TICK_CYCLES - 1);

   nhb_tick_state_type st_ff;
   nhb_tick_state_type nxt_st;

   // ---------------------------------------------------------------
   // Divider
   // ---------------------------------------------------------------
   // Count up and pulse on wrap; a load starts a fresh unit.
   always_comb begin
      nxt_st = st_ff;
      nxt_st.tick = 1'b0;
      if (hb.load) begin
         nxt_st.cnt = '0;
      end else if (st_ff.cnt == CNT_END) begin
         nxt_st.cnt = '0;
         nxt_st.tick = 1'b1;
      end else begin
         nxt_st.cnt = st_ff.cnt + nhb_pkg::TICK_W'(1);
      end
   end

   // State register.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign hb.tick = st_ff.tick;
endmodule
`default_nettype wire

// ===== core/nhb_beat.sv
// Purpose: Counts heartbeat units and pulses once per configured period.
// Assumes: Period and load arrive together from registers of the dictionary.
// Notes: A zero period parks the timer so no beat is ever produced.
`timescale 1ns/1ps
`default_nettype none
module nhb_beat (
   input wire logic clock,
   input wire logic arst_n,
   nhb_hb_if.bt hb
);
   typedef struct packed {
      nhb_pkg::nhb_hb_state_type state;
      logic [15:0] cnt;
      logic [15:0] period;
      logic beat;
   } nhb_beat_state_type;

   nhb_beat_state_type st_ff;
   nhb_beat_state_type nxt_st;

   // ---------------------------------------------------------------
   // Interval counter
   // ---------------------------------------------------------------
   // The period is latched at load; a later write reloads it and restarts the running interval.
   always_comb begin
      nxt_st = st_ff;
      nxt_st.beat = 1'b0;
      if (hb.load) begin
         nxt_st.period = hb.period;
         nxt_st.cnt = hb.period;
         if (hb.period == nhb_pkg::HB_PERIOD_RESET) begin
            nxt_st.state = nhb_pkg::NHB_HB_OFF;
         end else begin
            nxt_st.state = nhb_pkg::NHB_HB_RUN;
         end
      end else begin
         case (st_ff.state)
            nhb_pkg::NHB_HB_OFF: begin
               nxt_st.cnt = st_ff.cnt;
            end
            nhb_pkg::NHB_HB_RUN: begin
               if (hb.tick) begin
                  if (st_ff.cnt == nhb_pkg::HB_CNT_LAST) begin
                     nxt_st.beat = 1'b1;
                     nxt_st.cnt = st_ff.period;
                  end else begin
                     nxt_st.cnt = st_ff.cnt - 16'h1;
                  end
               end
            end
            default: begin
               nxt_st.state = nhb_pkg::NHB_HB_OFF;
            end
         endcase
      end
   end

   // State register.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign hb.beat = st_ff.beat;
endmodule
`default_nettype wire

// ===== core/nhb_top.sv
// Purpose: Heartbeat period, identity, build information and fault reaction dictionary entries of a field node.
// Assumes: One dictionary access at a time on the od_ port; fault inputs are one-cycle pulses.
// Notes: Every access is answered on the cycle after od_req with od_ack, and od_abort when refused.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - A non-zero heartbeat period makes the node send heartbeats cyclically, and zero sends none.
// - The heartbeat period is a 16-bit read/write count of 1 ms units, zero after reset, valid from 10 to 65535.
// - The identity record reports four entries: vendor code, product code, revision word and serial number.
// - The revision word packs dictionary major, software major, software minor and hardware minor, MSB first.
// - The build date holds the day in its top byte, the month next and the year in the low two bytes.
// - The build time reads zero in its upper two bytes and hour then minute in 24-hour form below.
// - The build information array reports two read-only entries, date and time.
// - A reaction code of 0 goes to pre-operational, 1 keeps the state, 2 goes to stopped.
// - A missed receive deadline or a missing lifeguard or heartbeat message flags a network fault; here a deadline miss counts only while node_operational.
// - The fault reaction array reports five 8-bit read/write codes, each reset to 1.
// - A missing consumed heartbeat raises a communication error handled by the communication entry.
// - A receive deadline missed while operational raises a network fault with its state reaction.
module nhb_top #(
   parameter int TICK_CYCLES = nhb_pkg::TICK_CYCLES,
   parameter logic [31:0] VENDOR_CODE = 32'h0000_0abc, // Arbitrary value.
   parameter logic [31:0] PRODUCT_CODE = 32'h0000_0def, // Arbitrary value.
   parameter logic [31:0] SERIAL_WORD = 32'h0000_0001,
   parameter logic [7:0] BUILD_DAY = 8'h01,
   parameter logic [7:0] BUILD_MONTH = 8'h01,
   parameter logic [15:0] BUILD_YEAR = 16'h2000,
   parameter logic [7:0] BUILD_HOUR = 8'h00,
   parameter logic [7:0] BUILD_MINUTE = 8'h00
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic od_req,
   input wire logic od_wr,
   input wire logic [15:0] od_index,
   input wire logic [7:0] od_sub,
   input wire logic [31:0] od_wdata,
   output logic od_ack,
   output logic od_abort,
   output logic [1:0] od_abort_why,
   output logic [31:0] od_rdata,
   output logic hb_req,
   input wire logic hb_done,
   input wire logic node_operational,
   input wire logic [nhb_pkg::RPDO_COUNT-1:0] rpdo_timeout,
   input wire logic consumer_hb_miss,
   input wire logic lifeguard_miss,
   input wire logic dig_in_fault,
   input wire logic ana_in_fault,
   input wire logic dig_out_fault,
   input wire logic ana_out_fault,
   output logic comm_error,
   output logic state_req,
   output logic state_req_stopped
);
   typedef struct packed {
      logic [15:0] hb_period;
      logic [nhb_pkg::FAULT_CLASSES-1:0][7:0] react;
      logic hb_pend;
      logic load;
      logic ack;
      logic abort;
      nhb_pkg::nhb_abort_type why;
      logic [31:0] rdata;
      logic comm_err;
      logic go;
      nhb_pkg::nhb_go_type go_state;
   } nhb_top_state_type;

   localparam logic [31:0] REVISION_WORD = {nhb_pkg::REV_OD_MAJOR_RST, nhb_pkg::REV_SW_MAJOR_RST,
                                            nhb_pkg::REV_SW_MINOR_RST, nhb_pkg::REV_HW_MINOR_RST};
   localparam logic [31:0] DATE_WORD = {BUILD_DAY, BUILD_MONTH, BUILD_YEAR};
   localparam logic [31:0] TIME_WORD = {nhb_pkg::TIME_UPPER, BUILD_HOUR, BUILD_MINUTE};

   nhb_top_state_type st_ff;
   nhb_top_state_type nxt_st;
   logic comm_hit;
   logic [nhb_pkg::FAULT_CLASSES-1:0] fault_vec;
   logic [nhb_pkg::FAULT_CLASSES-1:0] act_change;
   logic [nhb_pkg::FAULT_CLASSES-1:0] act_stop;

   nhb_hb_if hb ();

   // ---------------------------------------------------------------
   // Decoding helpers
   // ---------------------------------------------------------------
   // True when the sub-index names one of the reaction codes.
   function automatic logic fault_sub_ok(input logic [7:0] sub);
      fault_sub_ok = (sub >= nhb_pkg::SUB_FAULT_FIRST) && (sub <= nhb_pkg::SUB_FAULT_LAST);
   endfunction

   // Slot of the reaction table behind a sub-index.
   function automatic logic [2:0] fault_slot(input logic [7:0] sub);
      logic [7:0] s;
      s = sub - nhb_pkg::SUB_FAULT_FIRST;
      fault_slot = s[2:0];
   endfunction

   // Reaction code to {state change, go stopped}.
   function automatic logic [1:0] react_decode(input logic [7:0] code);
      case (code)
         nhb_pkg::REACT_PREOP: react_decode = 2'h2;
         nhb_pkg::REACT_STOP: react_decode = 2'h3;
         default: react_decode = 2'h0;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // Fault classification
   // ---------------------------------------------------------------
   // A deadline miss only counts while operational; lost guard or heartbeat messages always count.
   assign comm_hit = ((|rpdo_timeout) & node_operational) | consumer_hb_miss | lifeguard_miss;
   assign fault_vec = {ana_out_fault, dig_out_fault, ana_in_fault, dig_in_fault, comm_hit};

   // Each class looks up its own reaction code.
   genvar g;
   generate
      for (g = 0; g < nhb_pkg::FAULT_CLASSES; g++) begin : g_react
         logic [1:0] dec;
         assign dec = react_decode(st_ff.react[g]);
         assign act_change[g] = fault_vec[g] & dec[1];
         assign act_stop[g] = fault_vec[g] & dec[0];
      end
   endgenerate

   // ---------------------------------------------------------------
   // Dictionary access and state update
   // ---------------------------------------------------------------
   // Answers land one cycle after the request; writes take effect on the same edge.
   always_comb begin
      nxt_st = st_ff;
      nxt_st.ack = 1'b0;
      nxt_st.load = 1'b0;
      // A new beat wins over a simultaneous completion so no heartbeat is lost.
      nxt_st.hb_pend = (st_ff.hb_pend & ~hb_done) | hb.beat;
      nxt_st.comm_err = comm_hit;
      nxt_st.go = |act_change;
      // Stopped is the stronger reaction, so it wins when classes disagree.
      nxt_st.go_state = (|act_stop) ? nhb_pkg::NHB_GO_STOPPED : nhb_pkg::NHB_GO_PREOP;
      if (od_req) begin
         nxt_st.ack = 1'b1;
         nxt_st.abort = 1'b0;
         nxt_st.why = nhb_pkg::NHB_ABT_NONE;
         nxt_st.rdata = '0;
         case (od_index)
            nhb_pkg::IDX_HB_PERIOD: begin
               if (od_sub != nhb_pkg::SUB_COUNT) begin
                  nxt_st.why = nhb_pkg::NHB_ABT_NO_OBJ;
               end else if (!od_wr) begin
                  nxt_st.rdata = {16'h0, st_ff.hb_period};
               end else if ((od_wdata[31:16] != 16'h0) ||
                            ((od_wdata[15:0] != nhb_pkg::HB_PERIOD_RESET) &&
                             (od_wdata[15:0] < nhb_pkg::HB_PERIOD_MIN))) begin
                  nxt_st.why = nhb_pkg::NHB_ABT_RANGE;
               end else begin
                  nxt_st.hb_period = od_wdata[15:0];
                  nxt_st.load = 1'b1;
               end
            end
            nhb_pkg::IDX_IDENTITY: begin
               if (od_wr) begin
                  nxt_st.why = nhb_pkg::NHB_ABT_READ_ONLY;
               end
               case (od_sub)
                  nhb_pkg::SUB_COUNT: nxt_st.rdata = {24'h0, nhb_pkg::IDENTITY_COUNT};
                  nhb_pkg::SUB_VENDOR: nxt_st.rdata = VENDOR_CODE;
                  nhb_pkg::SUB_PRODUCT: nxt_st.rdata = PRODUCT_CODE;
                  nhb_pkg::SUB_REVISION: nxt_st.rdata = REVISION_WORD;
                  nhb_pkg::SUB_SERIAL: nxt_st.rdata = SERIAL_WORD;
                  default: nxt_st.why = nhb_pkg::NHB_ABT_NO_OBJ;
               endcase
            end
            nhb_pkg::IDX_BUILD: begin
               if (od_wr) begin
                  nxt_st.why = nhb_pkg::NHB_ABT_READ_ONLY;
               end
               case (od_sub)
                  nhb_pkg::SUB_COUNT: nxt_st.rdata = {24'h0, nhb_pkg::BUILD_COUNT};
                  nhb_pkg::SUB_DATE: nxt_st.rdata = DATE_WORD;
                  nhb_pkg::SUB_TIME: nxt_st.rdata = TIME_WORD;
                  default: nxt_st.why = nhb_pkg::NHB_ABT_NO_OBJ;
               endcase
            end
            nhb_pkg::IDX_FAULT: begin
               if (od_sub == nhb_pkg::SUB_COUNT) begin
                  if (od_wr) begin
                     nxt_st.why = nhb_pkg::NHB_ABT_READ_ONLY;
                  end
                  nxt_st.rdata = {24'h0, nhb_pkg::FAULT_COUNT};
               end else if (!fault_sub_ok(od_sub)) begin
                  nxt_st.why = nhb_pkg::NHB_ABT_NO_OBJ;
               end else if (!od_wr) begin
                  nxt_st.rdata = {24'h0, st_ff.react[fault_slot(od_sub)]};
               end else if (od_wdata > {24'h0, nhb_pkg::REACT_STOP}) begin
                  nxt_st.why = nhb_pkg::NHB_ABT_RANGE;
               end else begin
                  nxt_st.react[fault_slot(od_sub)] = od_wdata[7:0];
               end
            end
            default: begin
               nxt_st.why = nhb_pkg::NHB_ABT_NO_OBJ;
            end
         endcase
         // A refused access returns no data.
         if (nxt_st.why != nhb_pkg::NHB_ABT_NONE) begin
            nxt_st.abort = 1'b1;
            nxt_st.rdata = '0;
         end
      end
   end

   // State register with the documented defaults.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         st_ff <= '0;
         st_ff.hb_period <= nhb_pkg::HB_PERIOD_RESET;
         st_ff.react <= {nhb_pkg::FAULT_CLASSES{nhb_pkg::REACT_RESET}};
         st_ff.why <= nhb_pkg::NHB_ABT_NONE;
         st_ff.go_state <= nhb_pkg::NHB_GO_PREOP;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ---------------------------------------------------------------
   // Heartbeat timing
   // ---------------------------------------------------------------
   // Period and load come from registers, so the timer sees a consistent pair.
   assign hb.load = st_ff.load;
   assign hb.period = st_ff.hb_period;

   nhb_tick #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_tick (
      .clock(clock),
      .arst_n(arst_n),
      .hb(hb)
   );

   nhb_beat u_beat (
      .clock(clock),
      .arst_n(arst_n),
      .hb(hb)
   );

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // One heartbeat queues at most; a beat landing while one waits merges with it.
   assign hb_req = st_ff.hb_pend;
   assign od_ack = st_ff.ack;
   assign od_abort = st_ff.abort;
   assign od_abort_why = st_ff.why;
   assign od_rdata = st_ff.rdata;
   assign comm_error = st_ff.comm_err;
   assign state_req = st_ff.go;
   assign state_req_stopped = st_ff.go_state;
endmodule
`default_nettype wire

// ===== tb/nhb_properties.sv
// Purpose: Port-level properties of the dictionary block.
// Assumes: One clock; reset is asynchronous and active low.
// Notes: Bound to every instance of the top module.
`timescale 1ns/1ps
`default_nettype none
module nhb_properties (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic od_req,
   input wire logic od_wr,
   input wire logic [15:0] od_index,
   input wire logic [7:0] od_sub,
   input wire logic [31:0] od_wdata,
   input wire logic od_ack,
   input wire logic od_abort,
   input wire logic [1:0] od_abort_why,
   input wire logic [31:0] od_rdata,
   input wire logic hb_req,
   input wire logic hb_done,
   input wire logic node_operational,
   input wire logic [3:0] rpdo_timeout,
   input wire logic consumer_hb_miss,
   input wire logic lifeguard_miss,
   input wire logic dig_in_fault,
   input wire logic ana_in_fault,
   input wire logic dig_out_fault,
   input wire logic ana_out_fault,
   input wire logic comm_error,
   input wire logic state_req
);
   // Deadline misses only count while the node is operational.
   wire logic comm_cause = consumer_hb_miss | lifeguard_miss | ((|rpdo_timeout) & node_operational);
   wire logic any_cause = comm_cause | dig_in_fault | ana_in_fault | dig_out_fault | ana_out_fault;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   sequence rd_s(logic [15:0] i, logic [7:0] s);
      od_req && !od_wr && od_index == i && od_sub == s;
   endsequence
   sequence wr_s(logic [15:0] i, logic [7:0] top);
      od_req && od_wr && od_index == i && od_sub <= top;
   endsequence
   ack_follows_a: assert property (od_req |=> od_ack)
      else $error("request left unanswered");
   ack_idle_a: assert property (!od_req |=> !od_ack)
      else $error("answer without a request");
   rev_word_a: assert property (rd_s(nhb_pkg::IDX_IDENTITY, 8'h03) |=> od_rdata == 32'h0001_0000)
      else $error("revision word wrong");
   id_ro_a: assert property (wr_s(nhb_pkg::IDX_IDENTITY, 8'h04) |=> od_abort && od_abort_why == 2'h2)
      else $error("identity write taken");
   build_ro_a: assert property (wr_s(nhb_pkg::IDX_BUILD, 8'h02) |=> od_abort && od_abort_why == 2'h2)
      else $error("build write taken");
   period_low_a: assert property (od_req && od_wr && od_index == nhb_pkg::IDX_HB_PERIOD && od_sub == 8'h00
      && od_wdata inside {[1:9]} |=> od_abort && od_abort_why == 2'h3) else $error("short period accepted");
   fault_count_a: assert property (rd_s(nhb_pkg::IDX_FAULT, 8'h00) |=> od_rdata == 32'h5)
      else $error("reaction count wrong");
   comm_err_a: assert property (1'b1 |=> comm_error == $past(comm_cause))
      else $error("comm error mismatch");
   hb_hold_a: assert property (hb_req && !hb_done |=> hb_req)
      else $error("pending heartbeat dropped");
   quiet_a: assert property (!any_cause |=> !state_req)
      else $error("spurious state request");
endmodule
bind nhb_top nhb_properties u_props (.clock, .arst_n, .od_req, .od_wr, .od_index, .od_sub, .od_wdata, .od_ack,
   .od_abort, .od_abort_why, .od_rdata, .hb_req, .hb_done, .node_operational, .rpdo_timeout, .consumer_hb_miss,
   .lifeguard_miss, .dig_in_fault, .ana_in_fault, .dig_out_fault, .ana_out_fault, .comm_error, .state_req);
`default_nettype wire

// ===== tb/nhb_hb_tx_model.sv
// Purpose: Heartbeat transmitter standing behind the block's beat request.
// Assumes: The request is a level held until the done pulse.
// Notes: The lag input makes the sender prompt or slow.
`timescale 1ns/1ps
`default_nettype none
module nhb_hb_tx_model (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic hb_req,
   input wire logic [3:0] lag,
   output logic hb_done
);
   logic [3:0] wait_ff;
   // Pulses lag plus one cycles after the request rises; clearing the count gives one pulse per request.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wait_ff <= 4'h0;
         hb_done <= 1'h0;
      end else begin
         hb_done <= hb_req && !hb_done && wait_ff == lag;
         wait_ff <= (hb_req && !hb_done && wait_ff != lag) ? wait_ff + 4'h1 : 4'h0;
      end
   end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: Self-checking bench for the heartbeat, identity and fault policy entries.
// Assumes: A short tick of four cycles stands in for one millisecond.
// Notes: Reaction codes and fault pulses come from a fixed-seed xorshift.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clock, arst_n, od_req, od_wr, od_ack, od_abort, hb_req, hb_done, node_operational;
   logic consumer_hb_miss, lifeguard_miss, comm_error, state_req, state_req_stopped;
   logic dig_in_fault, ana_in_fault, dig_out_fault, ana_out_fault;
   logic [15:0] od_index;
   logic [7:0] od_sub;
   logic [31:0] od_wdata, od_rdata, seed;
   logic [1:0] od_abort_why;
   logic [3:0] rpdo_timeout, lag;
   logic [9:0] f;
   logic [1:0] code [1:5];
   int n_errors, checks_done, n;
   nhb_top #(.TICK_CYCLES(4), .BUILD_DAY(8'h10), .BUILD_MONTH(8'h08), .BUILD_HOUR(8'h16), .BUILD_MINUTE(8'h20)) dut (
      .clock, .arst_n, .od_req, .od_wr, .od_index, .od_sub, .od_wdata, .od_ack, .od_abort, .od_abort_why,
      .od_rdata, .hb_req, .hb_done, .node_operational, .rpdo_timeout, .consumer_hb_miss, .lifeguard_miss,
      .dig_in_fault, .ana_in_fault, .dig_out_fault, .ana_out_fault, .comm_error, .state_req, .state_req_stopped);
   nhb_hb_tx_model partner (.clock, .arst_n, .hb_req, .lag, .hb_done);
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   // Expected {comm error, state request, stopped} for one set of fault pulses.
   function automatic logic [2:0] expect_react(input logic [9:0] p, input logic op);
      logic [5:1] hit;
      logic req = 1'h0, stp = 1'h0;
      hit = {p[9:6], p[0] | p[1] | ((|p[5:2]) & op)};
      for (int k = 1; k <= 5; k++) begin
         req |= hit[k] && code[k] != 2'h1;
         stp |= hit[k] && code[k] == 2'h2;
      end
      return {hit[1], req, stp};
   endfunction
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One access, answered on the next edge.
   task sdo(input logic wr, input logic [15:0] i, input logic [7:0] s, input logic [31:0] rx,
            input logic [1:0] why = 2'h0, input logic [31:0] d = 32'h0);
      @(posedge clock);
      od_req <= 1'h1;
      od_wr <= wr;
      od_index <= i;
      od_sub <= s;
      od_wdata <= d;
      @(posedge clock);
      od_req <= 1'h0;
      #1;
      chk("answer", {od_ack, od_abort, od_abort_why}, {1'h1, why != 2'h0, why});
      chk("rdata", od_rdata, rx);
   endtask
   task summarize;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      clock = 1'h0;
      forever #4 clock = ~clock;
   end
   initial begin
      #50000;
      n_errors++;
      summarize();
   end
   initial begin
      {arst_n, od_req, od_wr, od_index, od_sub, od_wdata, node_operational, rpdo_timeout} = '0;
      {consumer_hb_miss, lifeguard_miss, dig_in_fault, ana_in_fault, dig_out_fault, ana_out_fault, lag} = '0;
      seed = 32'h5b63;
      repeat (4) @(posedge clock);
      arst_n <= 1'h1;
      // Reset values and the fixed words.
      sdo(1'h0, 16'h1017, 8'h00, 32'h0);
      sdo(1'h0, 16'h1018, 8'h00, 32'h4);
      sdo(1'h0, 16'h1018, 8'h01, 32'h0abc);
      sdo(1'h0, 16'h1018, 8'h02, 32'h0def);
      sdo(1'h0, 16'h1018, 8'h03, 32'h0001_0000);
      sdo(1'h0, 16'h1018, 8'h04, 32'h1);
      sdo(1'h0, 16'h1020, 8'h00, 32'h2);
      sdo(1'h0, 16'h1020, 8'h01, 32'h1008_2000);
      sdo(1'h0, 16'h1020, 8'h02, 32'h0000_1620);
      sdo(1'h0, 16'h1029, 8'h00, 32'h5);
      for (int k = 1; k <= 5; k++) sdo(1'h0, 16'h1029, 8'(k), 32'h1);
      // Refused accesses store nothing.
      sdo(1'h1, 16'h1018, 8'h01, 32'h0, 2'h2, 32'h5);
      sdo(1'h1, 16'h1020, 8'h02, 32'h0, 2'h2, 32'h5);
      sdo(1'h1, 16'h1029, 8'h00, 32'h0, 2'h2, 32'h2);
      sdo(1'h0, 16'h1030, 8'h00, 32'h0, 2'h1);
      sdo(1'h1, 16'h1017, 8'h00, 32'h0, 2'h3, 32'h9);
      sdo(1'h1, 16'h1017, 8'h00, 32'h0, 2'h3, 32'h0001_000a);
      sdo(1'h1, 16'h1029, 8'h01, 32'h0, 2'h3, 32'h3);
      sdo(1'h0, 16'h1017, 8'h00, 32'h0);
      // Shortest period: first beat, then spacing with a slow sender.
      sdo(1'h1, 16'h1017, 8'h00, 32'h0, 2'h0, 32'ha);
      n = 1;
      while (!hb_req && n < 100) begin
         @(posedge clock);
         #1 n++;
      end
      chk("first beat", n >= 42 && n <= 44, 1);
      lag <= 4'h7;
      n = 0;
      do begin @(posedge clock); #1 n++; end while (hb_req && n < 100);
      do begin @(posedge clock); #1 n++; end while (!hb_req && n < 100);
      chk("beat spacing", n, 40);
      sdo(1'h1, 16'h1017, 8'h00, 32'h0);
      repeat (20) @(posedge clock);
      n = 0;
      repeat (100) begin @(posedge clock); #1 n += hb_req; end
      chk("beats while off", n, 0);
      // Random reaction codes against sparse random fault pulses.
      repeat (4) begin
         for (int k = 1; k <= 5; k++) begin
            seed = xs(seed);
            code[k] = 2'(seed % 3);
            sdo(1'h1, 16'h1029, 8'(k), 32'h0, 2'h0, {30'h0, code[k]});
            sdo(1'h0, 16'h1029, 8'(k), {30'h0, code[k]});
         end
         repeat (20) begin
            seed = xs(seed);
            f = seed[9:0] & seed[19:10] & seed[29:20];
            @(posedge clock);
            {ana_out_fault, dig_out_fault, ana_in_fault, dig_in_fault, rpdo_timeout} <= f[9:2];
            {lifeguard_miss, consumer_hb_miss, node_operational} <= {f[1:0], seed[30]};
            @(posedge clock);
            {ana_out_fault, dig_out_fault, ana_in_fault, dig_in_fault, rpdo_timeout} <= 8'h00;
            {lifeguard_miss, consumer_hb_miss, node_operational} <= 3'h0;
            #1;
            chk("reaction", {comm_error, state_req, state_req & state_req_stopped}, expect_react(f, seed[30]));
         end
      end
      summarize();
   end
endmodule
`default_nettype wire
